/* File: core/rier_log_mem.sv */
`timescale 1ns/1ps
// Entry memory, kept in arrival order
module rier_log_mem #(
    parameter int DEPTH = 16,
    parameter int W = 42,
    parameter int LW = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    rier_log_if.mem lg
);
    logic [W-1:0] mem_r [DEPTH]; // Entry storage
    logic [LW-2:0] wp_r, wp_nxt, rp_r, rp_nxt; // Pointers
    logic [LW-1:0] cnt_r, cnt_nxt; // Fill level
    logic do_push, do_pop;

    // Handshake terms
    always_comb begin
        do_push = lg.push_valid && (cnt_r != LW'(DEPTH));
        do_pop = lg.pop_ready && (cnt_r != '0);
        wp_nxt = do_push ? wp_r + 1'b1 : wp_r;
        rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + LW'(do_push) - LW'(do_pop);
    end

    // Pointer and level registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem_r[wp_r] <= lg.push_data;
        end
    end

    assign lg.push_ready = (cnt_r != LW'(DEPTH));
    assign lg.pop_valid = (cnt_r != '0);
    assign lg.pop_data = mem_r[rp_r];
    assign lg.level = cnt_r;
endmodule : rier_log_mem

/* File: core/rier_top.sv */
`timescale 1ns/1ps
// Error classifier and log for the redundant I/O side
module rier_top
    import rier_pkg::*;
#(
    parameter int NUM_UNIT = 16,
    parameter int NUM_GRP = 8,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_loc_err,
    input wire logic bus_fail,
    input wire logic [$clog2(NUM_UNIT)-1:0] expansion_unit,
    input wire logic access_timeout,
    input wire logic [15:0] tmo_addr,
    input wire logic [15:0] tmo_instr,
    input wire logic tmo_output,
    input wire logic tmo_comm,
    input wire logic tmo_irq_active,
    input wire logic cfg_missing,
    input wire logic [1:0] cfg_type,
    input wire logic [15:0] cfg_addr,
    input wire logic loc_fail,
    input wire logic [15:0] loc_addr,
    input wire logic [$clog2(NUM_GRP)-1:0] loc_group,
    input wire logic digital_input_a,
    input wire logic digital_input_b,
    input wire logic [15:0] dsc_bitbyte,
    input wire logic dsc_bad_subunit,
    input wire logic dq_value,
    input wire logic readback_input,
    input wire logic [15:0] rb_bitbyte,
    input wire logic peer_rb_err,
    output logic [NUM_UNIT-1:0] unit_passive,
    output logic [NUM_GRP-1:0] dq_group_passive,
    output logic rb_passive,
    output logic ext_fault
);
    import rier_pkg::*;
    localparam int NSRC = 7; // Event sources, index is priority
    localparam int LW = $clog2(DEPTH) + 1;

    rier_log_if #(.W(RIER_ENTRY_W), .LW(LW)) lg ();

    rier_log_mem #(.DEPTH(DEPTH), .W(RIER_ENTRY_W), .LW(LW)) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .lg(lg)
    );

    // Register bus state
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic wr_ctrl; // Control write accepted
    logic [31:0] rd_mux;
    logic rd_ok;
    // Event capture
    rier_entry_t ev [NSRC]; // Entries offered this cycle
    logic [NSRC-1:0] ev_hit; // Source pulses this cycle
    rier_entry_t pend_r [NSRC], pend_nxt [NSRC];
    logic [NSRC-1:0] pv_r, pv_nxt; // Pending flags
    logic [NSRC-1:0] sel; // One-hot winner
    rier_entry_t push_e;
    // Passivation and fault state
    logic [NUM_UNIT-1:0] eup_r, eup_nxt;
    logic [NUM_GRP-1:0] grp_r, grp_nxt;
    logic ext_r, ext_nxt;
    // Discrepancy timer
    logic [$clog2(RIER_DISC_CYC+1)-1:0] dcnt_r, dcnt_nxt;
    logic dsc_err;
    // Readback checker
    rier_rb_state_t rb_r, rb_nxt;
    logic [$clog2(RIER_RB_CYC+1)-1:0] rcnt_r, rcnt_nxt;
    logic dq_prev_r;
    logic rb_err;
    logic [$clog2(RIER_PEER_CYC+2)-1:0] own_age_r, own_age_nxt, peer_age_r, peer_age_nxt;

    // Read multiplexer
    always_comb begin
        rd_ok = 1'b1;
        rd_mux = 32'h00000000;
        unique case (paddr)
            RIER_CTRL_OFS: rd_mux = 32'h00000000;
            RIER_STAT_OFS: begin
                rd_mux[RIER_STAT_LVL_POS +: LW] = lg.level;
                rd_mux[RIER_STAT_RBPAS_BIT] = (rb_r == RIER_RB_FAIL);
                rd_mux[RIER_STAT_EXT_BIT] = ext_r;
                rd_mux[RIER_STAT_NONEMPTY_BIT] = lg.pop_valid;
            end
            RIER_HEAD_OFS: rd_mux = lg.pop_valid ? {22'h000000, push_head(lg.pop_data)} : 32'h00000000;
            RIER_INFO_OFS: rd_mux = lg.pop_valid ? lg.pop_data[31:0] : 32'h00000000;
            RIER_EUPS_OFS: rd_mux = 32'(eup_r);
            default: rd_ok = 1'b0;
        endcase
    end

    // Head word: code and info count
    function automatic logic [9:0] push_head(input logic [RIER_ENTRY_W-1:0] d);
        rier_entry_t e;
        e = rier_entry_t'(d);
        return {e.ninfo, e.code};
    endfunction : push_head

    // APB slave: answer one cycle after setup
    always_comb begin
        pready_nxt = psel && !penable && !pready_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            prdata_nxt = pwrite ? 32'h00000000 : rd_mux;
            pslverr_nxt = !rd_ok;
        end
        wr_ctrl = psel && penable && pready_r && pwrite && (paddr == RIER_CTRL_OFS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Build entries for each source
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            ev[i] = '0;
        end
        ev[0].code = RIER_E_SYNC; // see [RULE1]
        ev[1] = '{RIER_E_BUS, 2'd1, 16'(expansion_unit), 16'h0000}; // see [RULE2]
        ev[2].ninfo = 2'd2; // see [RULE4]
        ev[2].info1 = tmo_addr;
        ev[2].info2 = tmo_instr;
        if (tmo_comm) begin
            ev[2].code = tmo_output ? RIER_E_TMO_COUT : RIER_E_TMO_CIN; // see [RULE6]
        end else if (tmo_output) begin
            ev[2].code = RIER_E_TMO_OUT; // see [RULE4]
        end else if (tmo_irq_active && tmo_addr == RIER_BYTE0_ADDR) begin
            ev[2].code = RIER_E_TMO_BYTE0; // see [RULE5]
        end else begin
            ev[2].code = RIER_E_TMO_IN;
        end
        ev[3] = '{RIER_E_CFG_BASE + 8'(cfg_type), 2'd1, cfg_addr, 16'h0000}; // see [RULE7]
        ev[4] = '{RIER_E_LOC, 2'd1, loc_addr, 16'h0000}; // see [RULE8]
        ev[5] = '{RIER_E_DSC, 2'd2, dsc_bitbyte, {15'h0000, dsc_bad_subunit}}; // see [RULE9]
        ev[6] = '{RIER_E_DQ, 2'd2, rb_bitbyte, {15'h0000, readback_input}}; // see [RULE10]
        ev_hit = {rb_err, dsc_err, loc_fail, cfg_missing, access_timeout, bus_fail, sync_loc_err};
    end

    // Pending slots: lowest index goes first, new event beats a drain
    always_comb begin
        sel = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pv_r[i]) begin
                sel = NSRC'(1) << i;
            end
        end
        push_e = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (sel[i]) begin
                push_e = pend_r[i];
            end
        end
        for (int i = 0; i < NSRC; i++) begin
            pv_nxt[i] = pv_r[i] && !(sel[i] && lg.push_ready);
            pend_nxt[i] = pend_r[i];
            if (ev_hit[i]) begin
                pv_nxt[i] = 1'b1;
                pend_nxt[i] = ev[i];
            end
        end
    end

    assign lg.push_valid = |sel; // see [RULE12]
    assign lg.push_data = push_e;
    assign lg.pop_ready = wr_ctrl && pwdata[RIER_CTRL_POP_BIT];

    // Passivation masks; a failure beats a same-cycle depassivation
    always_comb begin
        eup_nxt = eup_r;
        grp_nxt = grp_r;
        if (wr_ctrl && pwdata[RIER_CTRL_DEPASS_BIT]) begin
            eup_nxt = '0; // see [RULE3]
            grp_nxt = '0;
        end
        if (bus_fail) begin
            eup_nxt[expansion_unit] = 1'b1; // see [RULE2]
        end
        if (loc_fail) begin
            grp_nxt[loc_group] = 1'b1; // see [RULE8]
        end
    end

    // Discrepancy timer: one report per lasting mismatch
    always_comb begin
        dcnt_nxt = '0;
        dsc_err = 1'b0;
        if (digital_input_a != digital_input_b) begin
            dcnt_nxt = dcnt_r;
            if (dcnt_r < RIER_DISC_CYC) begin
                dcnt_nxt = dcnt_r + 1'b1;
            end
            dsc_err = (dcnt_r == RIER_DISC_CYC - 1); // see [RULE9]
        end
    end

    // Readback checker and peer coincidence
    always_comb begin
        rb_nxt = rb_r;
        rcnt_nxt = rcnt_r;
        rb_err = 1'b0;
        unique case (rb_r)
            RIER_RB_IDLE: begin
                rcnt_nxt = '0;
                if (dq_value != dq_prev_r || readback_input != dq_value) begin
                    rb_nxt = RIER_RB_WAIT;
                end
            end
            RIER_RB_WAIT: begin
                rcnt_nxt = rcnt_r + 1'b1;
                if (dq_value != dq_prev_r) begin
                    rcnt_nxt = '0;
                end else if (readback_input == dq_value) begin
                    rb_nxt = RIER_RB_IDLE;
                end else if (rcnt_r == RIER_RB_CYC - 1) begin
                    rb_err = 1'b1; // see [RULE10]
                    rb_nxt = RIER_RB_FAIL; // see [RULE11]
                end
            end
            RIER_RB_FAIL: begin
                if (wr_ctrl && pwdata[RIER_CTRL_RBREL_BIT]) begin
                    rb_nxt = RIER_RB_IDLE;
                end
            end
        endcase
        own_age_nxt = rb_err ? '0 : (own_age_r <= RIER_PEER_CYC ? own_age_r + 1'b1 : own_age_r);
        peer_age_nxt = peer_rb_err ? '0 : (peer_age_r <= RIER_PEER_CYC ? peer_age_r + 1'b1 : peer_age_r);
        ext_nxt = ext_r;
        if (wr_ctrl && pwdata[RIER_CTRL_RBREL_BIT]) begin
            ext_nxt = 1'b0;
        end
        if ((rb_err && (peer_rb_err || peer_age_r <= RIER_PEER_CYC))
            || (peer_rb_err && own_age_r <= RIER_PEER_CYC)) begin
            ext_nxt = 1'b1; // see [RULE11]
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pv_r <= '0;
            for (int i = 0; i < NSRC; i++) begin
                pend_r[i] <= '0;
            end
            eup_r <= '0;
            grp_r <= '0;
            dcnt_r <= '0;
            rb_r <= RIER_RB_IDLE;
            rcnt_r <= '0;
            dq_prev_r <= 1'b0;
            ext_r <= 1'b0;
            own_age_r <= '1;
            peer_age_r <= '1;
        end else begin
            pv_r <= pv_nxt;
            for (int i = 0; i < NSRC; i++) begin
                pend_r[i] <= pend_nxt[i];
            end
            eup_r <= eup_nxt;
            grp_r <= grp_nxt;
            dcnt_r <= dcnt_nxt;
            rb_r <= rb_nxt;
            rcnt_r <= rcnt_nxt;
            dq_prev_r <= dq_value;
            ext_r <= ext_nxt;
            own_age_r <= own_age_nxt;
            peer_age_r <= peer_age_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign unit_passive = eup_r;
    assign dq_group_passive = grp_r;
    assign rb_passive = rb_r[2]; // One-hot fail bit
    assign ext_fault = ext_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence bus_loss_s;
        bus_fail ##0 !pv_r[1];
    endsequence
    sync_code_a: assert property (sync_loc_err |=> pv_r[0] && pend_r[0].code == 8'h27) // see [RULE1]
        else $error("sync mismatch not pending as 39");
    bus_log_a: assert property (bus_loss_s |=> pend_r[1].code == 8'h28 // see [RULE2]
        && pend_r[1].info1 == 16'($past(expansion_unit))) else $error("bus loss entry wrong");
    unit_pass_a: assert property (bus_fail |=> unit_passive[$past(expansion_unit)]) // see [RULE2]
        else $error("unit not passivated");
    tmo_out_a: assert property (access_timeout && tmo_output && !tmo_comm |=> pend_r[2].code == 8'h33) // see [RULE4]
        else $error("output timeout not 51");
    tmo_byte0_a: assert property (access_timeout && !tmo_output && !tmo_comm && tmo_irq_active // see [RULE5]
        && tmo_addr == 16'h0000 |=> pend_r[2].code == 8'h34)
        else $error("input byte zero timeout not 52");
    tmo_comm_a: assert property (access_timeout && tmo_comm |=> // see [RULE6]
        pend_r[2].code == ($past(tmo_output) ? 8'h36 : 8'h35)) else $error("comm flag timeout code wrong");
    cfg_code_a: assert property (cfg_missing |=> pend_r[3].code == 8'h37 + 8'($past(cfg_type))) // see [RULE7]
        else $error("missing byte code wrong");
    grp_pass_a: assert property (loc_fail |=> dq_group_passive[$past(loc_group)] && pv_r[4]) // see [RULE8]
        else $error("group not passivated");
    disc_time_a: assert property (dsc_err |-> $past(digital_input_a, RIER_DISC_CYC - 1) // see [RULE9]
        != $past(digital_input_b, RIER_DISC_CYC - 1)) else $error("discrepancy reported early");
    rb_pass_a: assert property (rb_err |=> rb_passive && pend_r[6].info2[0] == $past(readback_input)) // see [RULE11]
        else $error("readback not passivated");
    order_a: assert property (lg.push_valid && lg.push_ready |=> // see [RULE12]
        lg.level == $past(lg.level) + 1'b1 || $past(lg.pop_ready)) else $error("entry not stored");
endmodule : rier_top

/* File: dv/rier_io_model.sv */
`timescale 1ns/1ps
// Far side: expansion units and redundant I/O, raising faults on command
module rier_io_model #(
    parameter int EW = 4,
    parameter int GW = 3
) (
    input wire logic pclk,
    output logic sync_loc_err,
    output logic bus_fail,
    output logic [EW-1:0] expansion_unit,
    output logic access_timeout,
    output logic [15:0] tmo_addr,
    output logic [15:0] tmo_instr,
    output logic tmo_output,
    output logic tmo_comm,
    output logic tmo_irq_active,
    output logic cfg_missing,
    output logic [1:0] cfg_type,
    output logic [15:0] cfg_addr,
    output logic loc_fail,
    output logic [15:0] loc_addr,
    output logic [GW-1:0] loc_group,
    output logic digital_input_a,
    output logic digital_input_b,
    output logic [15:0] dsc_bitbyte,
    output logic dsc_bad_subunit,
    output logic dq_value,
    output logic readback_input,
    output logic [15:0] rb_bitbyte,
    output logic peer_rb_err
);
    // Quiet at time zero, qualifiers hold a junk pattern
    initial begin
        {sync_loc_err, bus_fail, access_timeout, cfg_missing, loc_fail, peer_rb_err} = 6'h00;
        {expansion_unit, loc_group, cfg_type} = '1;
        {tmo_addr, tmo_instr, cfg_addr, loc_addr} = {4{16'hA5A5}};
        {tmo_output, tmo_comm, tmo_irq_active} = 3'h7;
        {digital_input_a, digital_input_b, dq_value, readback_input, dsc_bad_subunit} = 5'h00;
        dsc_bitbyte = 16'h0305;
        rb_bitbyte = 16'h0702;
    end

    // Unit bus loss, optionally with a sync mismatch in the same cycle
    task automatic bus_loss(input logic [EW-1:0] unit, input logic with_sync);
        @(posedge pclk);
        bus_fail <= 1'b1;
        sync_loc_err <= with_sync;
        expansion_unit <= unit;
        @(posedge pclk);
        bus_fail <= 1'b0;
        sync_loc_err <= 1'b0;
        expansion_unit <= ~unit;
    endtask : bus_loss

    // Access timeout; released qualifiers flip so stale values cannot match
    task automatic timeout(input logic [15:0] a, input logic [15:0] ins, input logic [2:0] f);
        @(posedge pclk);
        access_timeout <= 1'b1;
        tmo_addr <= a;
        tmo_instr <= ins;
        {tmo_output, tmo_comm, tmo_irq_active} <= f;
        @(posedge pclk);
        access_timeout <= 1'b0;
        tmo_addr <= ~a;
        tmo_instr <= ~ins;
        {tmo_output, tmo_comm, tmo_irq_active} <= ~f;
    endtask : timeout

    // Configured byte did not answer
    task automatic cfg_miss(input logic [1:0] t, input logic [15:0] a);
        @(posedge pclk);
        cfg_missing <= 1'b1;
        cfg_type <= t;
        cfg_addr <= a;
        @(posedge pclk);
        cfg_missing <= 1'b0;
        cfg_type <= ~t;
        cfg_addr <= ~a;
    endtask : cfg_miss

    // Locating output lost
    task automatic loc_loss(input logic [15:0] a, input logic [GW-1:0] g);
        @(posedge pclk);
        loc_fail <= 1'b1;
        loc_addr <= a;
        loc_group <= g;
        @(posedge pclk);
        loc_fail <= 1'b0;
        loc_addr <= ~a;
        loc_group <= ~g;
    endtask : loc_loss

    // Redundant input levels
    task automatic set_dsc(input logic a, input logic b, input logic bad);
        @(posedge pclk);
        digital_input_a <= a;
        digital_input_b <= b;
        dsc_bad_subunit <= bad;
    endtask : set_dsc

    // Output value and what the readback input shows
    task automatic set_dq(input logic v, input logic rb);
        @(posedge pclk);
        dq_value <= v;
        readback_input <= rb;
    endtask : set_dq

    // Other controller reports its own readback fault
    task automatic peer_pulse();
        @(posedge pclk);
        peer_rb_err <= 1'b1;
        @(posedge pclk);
        peer_rb_err <= 1'b0;
    endtask : peer_pulse
endmodule : rier_io_model

/* File: dv/rier_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the error reporter
module rier_top_tb;
    import rier_pkg::*;
    localparam int NUM_UNIT = 16;
    localparam int NUM_GRP = 8;
    localparam int EW = $clog2(NUM_UNIT);
    localparam int GW = $clog2(NUM_GRP);
    // Timeout table: {output, comm, irq} and expected code
    localparam logic [2:0] TF [6] = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h6, 3'h1};
    localparam logic [7:0] TC [6] = '{RIER_E_TMO_IN, RIER_E_TMO_OUT, RIER_E_TMO_BYTE0, RIER_E_TMO_CIN,
        RIER_E_TMO_COUT, RIER_E_TMO_IN};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sync_loc_err, bus_fail, access_timeout, tmo_output, tmo_comm, tmo_irq_active, cfg_missing;
    logic loc_fail, digital_input_a, digital_input_b, dsc_bad_subunit, dq_value, readback_input;
    logic peer_rb_err, rb_passive, ext_fault;
    logic [EW-1:0] expansion_unit;
    logic [GW-1:0] loc_group;
    logic [1:0] cfg_type;
    logic [15:0] tmo_addr, tmo_instr, cfg_addr, loc_addr, dsc_bitbyte, rb_bitbyte, ta;
    logic [NUM_UNIT-1:0] unit_passive;
    logic [NUM_GRP-1:0] dq_group_passive;
    int n_fail = 0;
    int num_checks = 0;

    // Device under test
    rier_top #(.NUM_UNIT(NUM_UNIT), .NUM_GRP(NUM_GRP), .DEPTH(16)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sync_loc_err, .bus_fail, .expansion_unit, .access_timeout, .tmo_addr, .tmo_instr,
        .tmo_output, .tmo_comm, .tmo_irq_active, .cfg_missing, .cfg_type, .cfg_addr, .loc_fail,
        .loc_addr, .loc_group, .digital_input_a, .digital_input_b, .dsc_bitbyte, .dsc_bad_subunit,
        .dq_value, .readback_input, .rb_bitbyte, .peer_rb_err, .unit_passive, .dq_group_passive,
        .rb_passive, .ext_fault);

    // Expansion side model
    rier_io_model #(.EW(EW), .GW(GW)) pm (
        .pclk, .sync_loc_err, .bus_fail, .expansion_unit, .access_timeout, .tmo_addr, .tmo_instr,
        .tmo_output, .tmo_comm, .tmo_irq_active, .cfg_missing, .cfg_type, .cfg_addr, .loc_fail,
        .loc_addr, .loc_group, .digital_input_a, .digital_input_b, .dsc_bitbyte, .dsc_bad_subunit,
        .dq_value, .readback_input, .rb_bitbyte, .peer_rb_err);

    // Clock at 25 MHz
    always #20 pclk = ~pclk;

    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        check("access", 32'h1, 32'(n));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read head and info words, compare, then pop
    task automatic expect_entry(input logic [7:0] c, input logic [1:0] n, input logic [15:0] i1,
        input logic [15:0] i2, input logic [15:0] m);
        apb(1'b0, RIER_HEAD_OFS, 32'h0);
        check("head", {22'h0, n, c}, {22'h0, rd[9:0]});
        apb(1'b0, RIER_INFO_OFS, 32'h0);
        if (n != 2'h0) check("info1", {16'h0, i1}, {16'h0, rd[31:16]});
        if (n == 2'h2) check("info2", {16'h0, i2}, {16'h0, rd[15:0] & m});
        apb(1'b1, RIER_CTRL_OFS, 32'h2);
    endtask : expect_entry

    // Verdict and end of run
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        test_done();
    end

    // Main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, RIER_STAT_OFS, 32'h0);
        check("status", 32'h0, rd);
        check("outputs", 32'h0, {6'h0, unit_passive, dq_group_passive, rb_passive, ext_fault});
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        check("slverr", 32'h1, {31'h0, rerr});
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", 32'h0, rd);
        check("slverr", 32'h1, {31'h0, rerr});
        // Sync mismatch and bus loss together: lower code first
        pm.bus_loss(4'h5, 1'b1);
        repeat (4) @(posedge pclk);
        check("unit_passive", 32'h20, {16'h0, unit_passive});
        apb(1'b0, RIER_EUPS_OFS, 32'h0);
        check("eups", 32'h20, rd);
        apb(1'b0, RIER_STAT_OFS, 32'h0);
        check("level", 32'h0004_0002, rd);
        expect_entry(RIER_E_SYNC, 2'h0, 16'h0, 16'h0, 16'h0);
        expect_entry(RIER_E_BUS, 2'h1, 16'h0005, 16'h0, 16'h0);
        // Every timeout class, plus interrupt with a nonzero address
        for (int i = 0; i < 6; i++) begin
            ta = (i == 2) ? RIER_BYTE0_ADDR : 16'h0120 + 16'(i);
            pm.timeout(ta, 16'h9000 + 16'(i), TF[i]);
            repeat (3) @(posedge pclk);
            expect_entry(TC[i], 2'h2, ta, 16'h9000 + 16'(i), 16'hFFFF);
        end
        // Four missing bytes back to back, kept in order
        for (int t = 0; t < 4; t++) pm.cfg_miss(2'(t), 16'h0400 + 16'(t));
        repeat (4) @(posedge pclk);
        for (int t = 0; t < 4; t++) expect_entry(RIER_E_CFG_BASE + 8'(t), 2'h1, 16'h0400 + 16'(t),
            16'h0, 16'h0);
        // Locating output lost, then depassivation
        pm.loc_loss(16'h0210, 3'h6);
        repeat (3) @(posedge pclk);
        check("group", 32'h40, {24'h0, dq_group_passive});
        expect_entry(RIER_E_LOC, 2'h1, 16'h0210, 16'h0, 16'h0);
        apb(1'b1, RIER_CTRL_OFS, 32'h1);
        @(posedge pclk);
        check("depass", 32'h0, {8'h0, unit_passive, dq_group_passive});
        // Lasting discrepancy, not logged too early
        pm.set_dsc(1'b1, 1'b0, 1'b1);
        repeat (RIER_DISC_CYC - 20) @(posedge pclk);
        apb(1'b0, RIER_STAT_OFS, 32'h0);
        check("early", 32'h0, {31'h0, rd[RIER_STAT_NONEMPTY_BIT]});
        repeat (40) @(posedge pclk);
        pm.set_dsc(1'b0, 1'b0, 1'b1);
        expect_entry(RIER_E_DSC, 2'h2, 16'h0305, 16'h1, 16'h1);
        // Output stuck at 0, peer reports alongside
        pm.set_dq(1'b1, 1'b0);
        repeat (RIER_RB_CYC + 10) @(posedge pclk);
        pm.peer_pulse();
        repeat (3) @(posedge pclk);
        check("rb_ext", 32'h3, {30'h0, rb_passive, ext_fault});
        apb(1'b0, RIER_STAT_OFS, 32'h0);
        check("stat_rb", 32'h3, {30'h0, rd[RIER_STAT_EXT_BIT:RIER_STAT_RBPAS_BIT]});
        expect_entry(RIER_E_DQ, 2'h2, 16'h0702, 16'h0, 16'h1);
        pm.set_dq(1'b1, 1'b1);
        apb(1'b1, RIER_CTRL_OFS, 32'h4);
        @(posedge pclk);
        check("rb_rel", 32'h0, {30'h0, rb_passive, ext_fault});
        test_done();
    end
endmodule : rier_top_tb

/* File: pkg/rier_log_if.sv */
`timescale 1ns/1ps
// Log store handshake between the reporter and its entry memory
interface rier_log_if #(parameter int W = 42, parameter int LW = 5);
    logic push_valid; // Entry offered
    logic push_ready; // Memory has room
    logic [W-1:0] push_data;
    logic pop_valid; // Head entry present
    logic pop_ready; // Drop head entry
    logic [W-1:0] pop_data;
    logic [LW-1:0] level; // Entries held
    modport wr (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, level);
    modport mem (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
endinterface : rier_log_if

/* File: pkg/rier_pkg.sv */
//Contract
//[RULE1] Log 39 on subunit sync location mismatch
//[RULE2] Bus loss logs 40 with unit number
//[RULE3] Software sets depassivate flag after repair
//[RULE4] Timeouts log 50 input, 51 output
//[RULE5] Input byte zero timeout, interrupt: 52
//[RULE6] Communication flag timeouts log 53, 54
//[RULE7] Missing configured byte logs 55 to 58
//[RULE8] Locating output failure passivates group, logs 59
//[RULE9] Lasting input discrepancy logs 60 with subunit
//[RULE10] Readback mismatch logs 61 with stuck value
//[RULE11] Passivate readback input; peer coincidence external
//[RULE12] Entries stored in detection order; code stores pending entries by source index, lowest first
package rier_pkg;
    // Register byte offsets
    localparam logic [7:0] RIER_CTRL_OFS = 8'h00;
    localparam logic [7:0] RIER_STAT_OFS = 8'h04;
    localparam logic [7:0] RIER_HEAD_OFS = 8'h08;
    localparam logic [7:0] RIER_INFO_OFS = 8'h0C;
    localparam logic [7:0] RIER_EUPS_OFS = 8'h10;
    // Control bits, write-one actions
    localparam int RIER_CTRL_DEPASS_BIT = 0;
    localparam int RIER_CTRL_POP_BIT = 1;
    localparam int RIER_CTRL_RBREL_BIT = 2;
    // Status fields
    localparam int RIER_STAT_LVL_POS = 0;
    localparam int RIER_STAT_RBPAS_BIT = 16;
    localparam int RIER_STAT_EXT_BIT = 17;
    localparam int RIER_STAT_NONEMPTY_BIT = 18;
    // Error codes
    localparam logic [7:0] RIER_E_SYNC = 8'h27;
    localparam logic [7:0] RIER_E_BUS = 8'h28;
    localparam logic [7:0] RIER_E_TMO_IN = 8'h32;
    localparam logic [7:0] RIER_E_TMO_OUT = 8'h33;
    localparam logic [7:0] RIER_E_TMO_BYTE0 = 8'h34;
    localparam logic [7:0] RIER_E_TMO_CIN = 8'h35;
    localparam logic [7:0] RIER_E_TMO_COUT = 8'h36;
    localparam logic [7:0] RIER_E_CFG_BASE = 8'h37;
    localparam logic [7:0] RIER_E_LOC = 8'h3B;
    localparam logic [7:0] RIER_E_DSC = 8'h3C;
    localparam logic [7:0] RIER_E_DQ = 8'h3D;
    // Address of input byte zero
    localparam logic [15:0] RIER_BYTE0_ADDR = 16'h0000;
    // Timing in ns and derived cycle counts at 25 MHz
    localparam int RIER_CLK_NS = 40;
    localparam int RIER_DISC_NS = 40000;
    localparam int RIER_RB_NS = 20000;
    localparam int RIER_PEER_NS = 4000;
    localparam int RIER_DISC_CYC = (RIER_DISC_NS + RIER_CLK_NS - 1) / RIER_CLK_NS;
    localparam int RIER_RB_CYC = (RIER_RB_NS + RIER_CLK_NS - 1) / RIER_CLK_NS;
    localparam int RIER_PEER_CYC = RIER_PEER_NS / RIER_CLK_NS;
    // One log entry: code, info count, two info words
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] ninfo;
        logic [15:0] info1;
        logic [15:0] info2;
    } rier_entry_t;
    localparam int RIER_ENTRY_W = $bits(rier_entry_t);
    // Readback checker states
    typedef enum logic [2:0] {
        RIER_RB_IDLE = 3'b001,
        RIER_RB_WAIT = 3'b010,
        RIER_RB_FAIL = 3'b100
    } rier_rb_state_t;
endpackage : rier_pkg
